//--- remap_pin_defines.svh
// Constants for the remappable pin select block
`ifndef REMAP_PIN_DEFINES_SVH
`define REMAP_PIN_DEFINES_SVH
`define OUT_SEL_NULL 5'h00
`define OUT_SEL_UART_TX 5'h03
`define OUT_SEL_UART_RTS 5'h04
`define OUT_SEL_SPI_DO 5'h07
`define OUT_SEL_SPI_CLK 5'h08
`define OUT_SEL_SPI_SEL 5'h09
`define OUT_SEL_CMP_ONE 5'h12
`define OUT_SEL_CMP_TWO 5'h13
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'h57
`define LOCK_BIT_POS 6
`define FUSE_BIT_POS 5
`define NUM_OUT_PINS 8
`define NUM_IN_MAPS 9
`define MAP_IDX_W 5
`define IN_MAP_BASE 5'h00
`define OUT_MAP_BASE 5'h09
`define NUM_MAPS 17
`define OSC_RESET 16'h0000
`endif

//--- remap_pin_pkg.sv
// Types for the remappable pin select block
package remap_pin_pkg;
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT_FIRST,
		KEY_ARMED
	} key_state_type;
	typedef struct packed {
		logic valid;
		logic [4:0] index;
		logic [15:0] data;
	} map_write_type;
	typedef struct packed {
		logic low_valid;
		logic high_valid;
		logic [15:0] data;
	} osc_write_type;
	typedef struct packed {
		logic uart_tx;
		logic uart_rts;
		logic spi_do;
		logic spi_clk;
		logic spi_sel;
		logic cmp_one;
		logic cmp_two;
	} periph_out_type;
endpackage

//--- unlock_sequencer.sv
// Two-byte key tracker and write-lock holder
`timescale 1ns/1ps
`include "remap_pin_defines.svh"
module unlock_sequencer (
	input wire logic sys_clk,
	input wire logic resetn,
	input remap_pin_pkg::osc_write_type osc_wr,
	input wire logic other_wr,
	input wire logic one_way_fuse,
	output logic map_write_lock
);
	typedef struct packed {
		remap_pin_pkg::key_state_type key;
		logic lock;
		logic ever_set;
	} seq_state_type;
	seq_state_type state_q;
	seq_state_type state_d;
	logic low_byte_wr;
	logic new_lock;
	assign low_byte_wr = osc_wr.low_valid;
	assign new_lock = osc_wr.data[`LOCK_BIT_POS];
	assign map_write_lock = state_q.lock;

	//////////////////////////////////////////////////////////////////////
	// Key tracking; any stray write drops the tracker back to idle
	always_comb begin
		state_d = state_q;
		case (state_q.key)
			remap_pin_pkg::KEY_IDLE: begin
				if (low_byte_wr && osc_wr.data[7:0] == `KEY_FIRST) begin
					state_d.key = remap_pin_pkg::KEY_GOT_FIRST;
				end
			end
			remap_pin_pkg::KEY_GOT_FIRST: begin
				if (low_byte_wr && osc_wr.data[7:0] == `KEY_SECOND && !other_wr) begin
					state_d.key = remap_pin_pkg::KEY_ARMED;
				end else if (low_byte_wr || osc_wr.high_valid || other_wr) begin
					state_d.key = remap_pin_pkg::KEY_IDLE;
				end
			end
			default: begin
				if ((low_byte_wr || osc_wr.high_valid) && !other_wr) begin
					state_d.key = remap_pin_pkg::KEY_IDLE;
					if (new_lock || !(one_way_fuse && state_q.ever_set)) begin
						state_d.lock = new_lock;
					end
				end else if (other_wr) begin
					state_d.key = remap_pin_pkg::KEY_IDLE;
				end
			end
		endcase
		// remember that the lock was set this session
		if (state_d.lock) begin
			state_d.ever_set = 1'b1;
		end
	end

	// Lock holds until changed through the key
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{remap_pin_pkg::KEY_IDLE, 1'b0, 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	// single session: never clears once set
	property p_one_way_hold;
		@(posedge sys_clk) disable iff (!resetn)
		(one_way_fuse && state_q.ever_set && map_write_lock) |=> map_write_lock;
	endproperty
	a_one_way_hold: assert property (p_one_way_hold) else $error("lock cleared in one-way");
	// lock changes only right after the armed state
	property p_lock_change_armed;
		@(posedge sys_clk) disable iff (!resetn)
		$changed(map_write_lock) |-> $past(state_q.key) == remap_pin_pkg::KEY_ARMED;
	endproperty
	a_lock_change_armed: assert property (p_lock_change_armed) else $error("lock change unarmed");
	// key bytes in order arm the tracker
	sequence s_key_pair;
		(low_byte_wr && osc_wr.data[7:0] == `KEY_FIRST && state_q.key == remap_pin_pkg::KEY_IDLE)
		##1 (low_byte_wr && osc_wr.data[7:0] == `KEY_SECOND && !other_wr);
	endsequence
	property p_key_arms;
		@(posedge sys_clk) disable iff (!resetn)
		s_key_pair |=> state_q.key == remap_pin_pkg::KEY_ARMED;
	endproperty
	a_key_arms: assert property (p_key_arms) else $error("key pair did not arm");
	// stray write while waiting returns to idle
	property p_stray_idle;
		@(posedge sys_clk) disable iff (!resetn)
		(state_q.key == remap_pin_pkg::KEY_GOT_FIRST && other_wr)
		|=> state_q.key == remap_pin_pkg::KEY_IDLE;
	endproperty
	a_stray_idle: assert property (p_stray_idle) else $error("tracker not reset");
	property p_multi_session;
		@(posedge sys_clk) disable iff (!resetn)
		(!one_way_fuse && state_q.key == remap_pin_pkg::KEY_ARMED && low_byte_wr && !new_lock
			&& !other_wr) |=> !map_write_lock;
	endproperty
	a_multi_session: assert property (p_multi_session) else $error("unlock refused");
endmodule

//--- output_selector.sv
// Output function multiplexer for one remappable pin
`timescale 1ns/1ps
`include "remap_pin_defines.svh"
module output_selector (
	input wire logic [4:0] func_sel,
	input remap_pin_pkg::periph_out_type periph,
	input wire logic port_latch,
	output logic pin_out
);
	// Unlisted codes fall back to the port latch
	always_comb begin
		case (func_sel)
			`OUT_SEL_NULL: pin_out = port_latch;
			`OUT_SEL_UART_TX: pin_out = periph.uart_tx;
			`OUT_SEL_UART_RTS: pin_out = periph.uart_rts;
			`OUT_SEL_SPI_DO: pin_out = periph.spi_do;
			`OUT_SEL_SPI_CLK: pin_out = periph.spi_clk;
			`OUT_SEL_SPI_SEL: pin_out = periph.spi_sel;
			`OUT_SEL_CMP_ONE: pin_out = periph.cmp_one;
			`OUT_SEL_CMP_TWO: pin_out = periph.cmp_two;
			default: pin_out = port_latch;
		endcase
	end
endmodule

//--- remap_pin_select_lock.sv
// Remappable pin select maps, write lock and shadow monitor
//
// Behaviour
// - Code 00000 gives port latch; 00011 UART transmit; 00100 request-to-send.
// - Codes 00111, 01000, 01001 give SPI data, clock, select.
// - Codes 10010 and 10011 give compare channels one and two.
// - Locked map writes complete normally but change nothing.
// - Lock is bit 6 of oscillator control; one blocks writes.
// - Lock bit changes only in the single write right after key.
// - Lock holds its value until explicitly changed.
// - Shadows compare all maps; unpermitted change raises mismatch reset.
// - One-way fuse, config bit 5, forbids clearing lock once set.
// - In one-way mode only device reset reopens the maps.
// - Fuse reads set when unprogrammed; programmed allows many sessions.
`timescale 1ns/1ps
`include "remap_pin_defines.svh"
module remap_pin_select_lock (
	input wire logic sys_clk,
	input wire logic resetn,
	input remap_pin_pkg::osc_write_type osc_wr,
	input remap_pin_pkg::map_write_type map_wr,
	input wire logic [7:0] osc_config_word,
	input remap_pin_pkg::periph_out_type periph,
	input wire logic [`NUM_OUT_PINS-1:0] port_latch,
	input wire logic [4:0] map_rd_index,
	output logic [15:0] map_rd_data,
	output logic [7:0] osc_control_reg,
	output logic map_write_lock,
	output logic single_session_lock_fuse,
	output logic [`NUM_OUT_PINS-1:0] pin_out,
	output logic config_mismatch_reset
);
	typedef struct packed {
		logic [`NUM_MAPS-1:0][15:0] maps;
		logic [`NUM_MAPS-1:0][15:0] shadow;
		logic [15:0] rd_data;
		logic mismatch;
	} top_state_type;
	top_state_type state_q;
	top_state_type state_d;
	logic [`NUM_OUT_PINS-1:0][4:0] out_field;
	logic other_wr;
	logic map_accepted;
	logic any_diff;

	//////////////////////////////////////////////////////////////////////
	// Fuse and key tracker
	// unprogrammed fuse reads one
	assign single_session_lock_fuse = osc_config_word[`FUSE_BIT_POS];
	assign other_wr = map_wr.valid;

	unlock_sequencer unlock_sequencer_inst (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.osc_wr(osc_wr),
		.other_wr(other_wr),
		.one_way_fuse(single_session_lock_fuse),
		.map_write_lock(map_write_lock)
	);

	// lock visible at bit 6 of control low byte
	always_comb begin
		osc_control_reg = 8'h00;
		osc_control_reg[`LOCK_BIT_POS] = map_write_lock;
	end

	// Index beyond the map set is ignored
	function automatic logic index_ok(input logic [4:0] idx);
		index_ok = idx < 5'(`NUM_MAPS);
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Map registers, shadows and mismatch detection
	// locked write is silently dropped
	assign map_accepted = map_wr.valid && !map_write_lock && index_ok(map_wr.index);

	// Any shadow disagreement flags a disturbed cell
	always_comb begin
		any_diff = 1'b0;
		for (int i = 0; i < `NUM_MAPS; i++) begin
			if (state_q.maps[i] != state_q.shadow[i]) begin
				any_diff = 1'b1;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		if (map_accepted) begin
			// Map and shadow move together on a permitted write
			state_d.maps[map_wr.index] = map_wr.data;
			state_d.shadow[map_wr.index] = map_wr.data;
		end
		state_d.mismatch = any_diff;
		state_d.rd_data = index_ok(map_rd_index) ? state_q.maps[map_rd_index] : 16'h0000;
	end

	// Device reset clears maps so pins return to port latches
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign map_rd_data = state_q.rd_data;
	assign config_mismatch_reset = state_q.mismatch;

	//////////////////////////////////////////////////////////////////////
	// Output routing: output map registers 9 to 12 each hold two pin fields
	for (genvar p = 0; p < `NUM_OUT_PINS; p++) begin : g_pin
		assign out_field[p] = state_q.maps[`OUT_MAP_BASE + p/2][(p%2)*8 +: 5];
		output_selector output_selector_inst (
			.func_sel(out_field[p]),
			.periph(periph),
			.port_latch(port_latch[p]),
			.pin_out(pin_out[p])
		);
	end

	//////////////////////////////////////////////////////////////////////
	// Checks
	// locked write leaves map unchanged
	property p_locked_hold;
		@(posedge sys_clk) disable iff (!resetn)
		(map_wr.valid && map_write_lock && index_ok(map_wr.index))
		|=> state_q.maps[$past(map_wr.index)] == $past(state_q.maps[map_wr.index]);
	endproperty
	a_locked_hold: assert property (p_locked_hold) else $error("locked write changed map");
	property p_unlocked_write;
		@(posedge sys_clk) disable iff (!resetn)
		map_accepted |=> state_q.maps[$past(map_wr.index)] == $past(map_wr.data);
	endproperty
	a_unlocked_write: assert property (p_unlocked_write) else $error("write lost");
	// mismatch follows disagreement by one cycle
	property p_mismatch;
		@(posedge sys_clk) disable iff (!resetn)
		any_diff |=> config_mismatch_reset;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");
	property p_no_false_mismatch;
		@(posedge sys_clk) disable iff (!resetn)
		!any_diff |=> !config_mismatch_reset;
	endproperty
	a_no_false_mismatch: assert property (p_no_false_mismatch) else $error("false mismatch");
	property p_lock_bit;
		@(posedge sys_clk) disable iff (!resetn)
		osc_control_reg[`LOCK_BIT_POS] == map_write_lock;
	endproperty
	a_lock_bit: assert property (p_lock_bit) else $error("lock bit wrong");
	// zero code drives pin from port latch
	property p_null_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[0] == `OUT_SEL_NULL |-> pin_out[0] == port_latch[0];
	endproperty
	a_null_route: assert property (p_null_route) else $error("null route wrong");
	property p_spi_clk_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[0] == `OUT_SEL_SPI_CLK |-> pin_out[0] == periph.spi_clk;
	endproperty
	a_spi_clk_route: assert property (p_spi_clk_route) else $error("spi clock route wrong");
	// second compare code routes channel two
	property p_cmp_two_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[1] == `OUT_SEL_CMP_TWO |-> pin_out[1] == periph.cmp_two;
	endproperty
	a_cmp_two_route: assert property (p_cmp_two_route) else $error("compare route wrong");
	// lock stays put without oscillator writes
	property p_lock_stable;
		@(posedge sys_clk) disable iff (!resetn)
		(!osc_wr.low_valid && !osc_wr.high_valid) |=> $stable(map_write_lock);
	endproperty
	a_lock_stable: assert property (p_lock_stable) else $error("lock drifted");

	//////////////////////////////////////////////////////////////////////
	// Route checks; pins 0 and 1 cover every code between them, pins 2, 4 and 6 one code each
	// transmit code routes the UART output
	property p_uart_tx_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[0] == `OUT_SEL_UART_TX |-> pin_out[0] == periph.uart_tx;
	endproperty
	a_uart_tx_route: assert property (p_uart_tx_route) else $error("tx route wrong");
	// request-to-send code routes on an odd pin
	property p_rts_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[1] == `OUT_SEL_UART_RTS |-> pin_out[1] == periph.uart_rts;
	endproperty
	a_rts_route: assert property (p_rts_route) else $error("rts route wrong");
	// zero code on an odd pin gives its latch
	property p_null_route_odd;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[1] == `OUT_SEL_NULL |-> pin_out[1] == port_latch[1];
	endproperty
	a_null_route_odd: assert property (p_null_route_odd) else $error("odd null route wrong");
	// SPI data code routes data out
	property p_spi_do_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[0] == `OUT_SEL_SPI_DO |-> pin_out[0] == periph.spi_do;
	endproperty
	a_spi_do_route: assert property (p_spi_do_route) else $error("spi data route wrong");
	// SPI select code routes select out
	property p_spi_sel_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[1] == `OUT_SEL_SPI_SEL |-> pin_out[1] == periph.spi_sel;
	endproperty
	a_spi_sel_route: assert property (p_spi_sel_route) else $error("spi select route wrong");
	// first compare code routes channel one
	property p_cmp_one_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[0] == `OUT_SEL_CMP_ONE |-> pin_out[0] == periph.cmp_one;
	endproperty
	a_cmp_one_route: assert property (p_cmp_one_route) else $error("compare one route wrong");
	// second output map drives pin 2
	property p_pin2_rts_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[2] == `OUT_SEL_UART_RTS |-> pin_out[2] == periph.uart_rts;
	endproperty
	a_pin2_rts_route: assert property (p_pin2_rts_route) else $error("pin 2 route wrong");
	// third output map drives pin 4
	property p_pin4_do_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[4] == `OUT_SEL_SPI_DO |-> pin_out[4] == periph.spi_do;
	endproperty
	a_pin4_do_route: assert property (p_pin4_do_route) else $error("pin 4 route wrong");
	// fourth output map drives pin 6
	property p_pin6_clk_route;
		@(posedge sys_clk) disable iff (!resetn)
		out_field[6] == `OUT_SEL_SPI_CLK |-> pin_out[6] == periph.spi_clk;
	endproperty
	a_pin6_clk_route: assert property (p_pin6_clk_route) else $error("pin 6 route wrong");

	//////////////////////////////////////////////////////////////////////
	// Lock, map and shadow checks
	// a set lock never lets a write through
	property p_lock_blocks;
		@(posedge sys_clk) disable iff (!resetn)
		map_write_lock |-> !map_accepted;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("write passed lock");
	// only the lock bit of the control byte is live
	property p_osc_reserved;
		@(posedge sys_clk) disable iff (!resetn)
		(osc_control_reg & ~(8'h01 << `LOCK_BIT_POS)) == 8'h00;
	endproperty
	a_osc_reserved: assert property (p_osc_reserved) else $error("reserved bit set");
	// lock moves only on the edge after a control write
	property p_lock_after_write;
		@(posedge sys_clk) disable iff (!resetn)
		$changed(map_write_lock) |-> $past(osc_wr.low_valid || osc_wr.high_valid);
	endproperty
	a_lock_after_write: assert property (p_lock_after_write) else $error("lock moved alone");
	// locked write leaves maps and shadows alone
	sequence s_locked_write;
		map_wr.valid && map_write_lock;
	endsequence
	property p_locked_quiet;
		@(posedge sys_clk) disable iff (!resetn)
		s_locked_write |=> $stable(state_q.maps) && $stable(state_q.shadow);
	endproperty
	a_locked_quiet: assert property (p_locked_quiet) else $error("locked write moved");
	// maps hold without an accepted write
	property p_maps_quiet;
		@(posedge sys_clk) disable iff (!resetn)
		!map_accepted |=> $stable(state_q.maps);
	endproperty
	a_maps_quiet: assert property (p_maps_quiet) else $error("map drifted");
	// index past the map set is dropped
	property p_bad_index_drop;
		@(posedge sys_clk) disable iff (!resetn)
		(map_wr.valid && !index_ok(map_wr.index)) |=> $stable(state_q.shadow);
	endproperty
	a_bad_index_drop: assert property (p_bad_index_drop) else $error("bad index stored");
	property p_shadow_follow;
		@(posedge sys_clk) disable iff (!resetn)
		map_accepted |=> state_q.shadow[$past(map_wr.index)] == $past(map_wr.data);
	endproperty
	a_shadow_follow: assert property (p_shadow_follow) else $error("shadow missed write");
	// shadow holds without a permitted write
	property p_shadow_quiet;
		@(posedge sys_clk) disable iff (!resetn)
		!map_accepted |=> $stable(state_q.shadow);
	endproperty
	a_shadow_quiet: assert property (p_shadow_quiet) else $error("shadow drifted");
	// a permitted write raises no mismatch reset
	property p_write_no_mismatch;
		@(posedge sys_clk) disable iff (!resetn)
		map_accepted |=> ##1 !config_mismatch_reset;
	endproperty
	a_write_no_mismatch: assert property (p_write_no_mismatch) else $error("write flagged");
	// read port returns the held map value
	property p_read_back;
		@(posedge sys_clk) disable iff (!resetn)
		index_ok(map_rd_index) |=> map_rd_data == $past(state_q.maps[map_rd_index]);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read back wrong");
	// read past the map set gives zero
	property p_bad_read_zero;
		@(posedge sys_clk) disable iff (!resetn)
		!index_ok(map_rd_index) |=> map_rd_data == 16'h0000;
	endproperty
	a_bad_read_zero: assert property (p_bad_read_zero) else $error("bad read not zero");
	// fuse output follows its config bit
	property p_fuse_mirror;
		@(posedge sys_clk) disable iff (!resetn)
		single_session_lock_fuse == osc_config_word[`FUSE_BIT_POS];
	endproperty
	a_fuse_mirror: assert property (p_fuse_mirror) else $error("fuse wrong");
endmodule

//--- remap_pin_select_lock_test.sv
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ps
`include "remap_pin_defines.svh"
module remap_pin_select_lock_test;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	remap_pin_pkg::osc_write_type osc_wr = '0;
	remap_pin_pkg::map_write_type map_wr = '0;
	logic [7:0] osc_config_word = 8'h00;
	remap_pin_pkg::periph_out_type periph = '0;
	logic [7:0] port_latch = 8'h00;
	logic [4:0] map_rd_index = 5'h00;
	logic [15:0] map_rd_data;
	logic [7:0] osc_control_reg;
	logic map_write_lock;
	logic single_session_lock_fuse;
	logic [7:0] pin_out;
	logic config_mismatch_reset;
	integer seed = 32'hbb49;
	integer fails = 0;
	integer checks_done = 0;
	logic [4:0] fcode;
	logic [4:0] codes [8] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13};

	remap_pin_select_lock remap_pin_select_lock_inst (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.osc_wr(osc_wr),
		.map_wr(map_wr),
		.osc_config_word(osc_config_word),
		.periph(periph),
		.port_latch(port_latch),
		.map_rd_index(map_rd_index),
		.map_rd_data(map_rd_data),
		.osc_control_reg(osc_control_reg),
		.map_write_lock(map_write_lock),
		.single_session_lock_fuse(single_session_lock_fuse),
		.pin_out(pin_out),
		.config_mismatch_reset(config_mismatch_reset)
	);

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Expected pin level for a function code; unknown codes fall back to the latch
	function automatic logic exp_pin(logic [4:0] code, remap_pin_pkg::periph_out_type p,
			logic latch);
		case (code)
			5'h03: exp_pin = p.uart_tx;
			5'h04: exp_pin = p.uart_rts;
			5'h07: exp_pin = p.spi_do;
			5'h08: exp_pin = p.spi_clk;
			5'h09: exp_pin = p.spi_sel;
			5'h12: exp_pin = p.cmp_one;
			5'h13: exp_pin = p.cmp_two;
			default: exp_pin = latch;
		endcase
	endfunction

	// Compare and count
	task automatic check(logic [15:0] got, logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write to the low oscillator control byte
	task automatic osc_write(logic [7:0] b);
		@(posedge sys_clk);
		#1;
		osc_wr.low_valid = 1'b1;
		osc_wr.data = {8'h00, b};
		@(posedge sys_clk);
		#1;
		osc_wr.low_valid = 1'b0;
	endtask

	// One-cycle write to the high byte, used as a stray write
	task automatic osc_write_high(logic [7:0] b);
		@(posedge sys_clk);
		#1;
		osc_wr.high_valid = 1'b1;
		osc_wr.data = {b, 8'h00};
		@(posedge sys_clk);
		#1;
		osc_wr.high_valid = 1'b0;
	endtask

	// One-cycle map register write
	task automatic map_write(logic [4:0] idx, logic [15:0] d);
		@(posedge sys_clk);
		#1;
		map_wr.valid = 1'b1;
		map_wr.index = idx;
		map_wr.data = d;
		@(posedge sys_clk);
		#1;
		map_wr.valid = 1'b0;
	endtask

	// Key pair then the lock bit in one write
	task automatic lock_seq(logic v);
		// key bytes in order, then the lock write
		osc_write(8'h46);
		osc_write(8'h57);
		osc_write({1'b0, v, 6'h00});
	endtask

	// Registered read-back, one cycle behind the index
	task automatic read_check(logic [4:0] idx, logic [15:0] exp);
		map_rd_index = idx;
		@(posedge sys_clk);
		#1;
		check(map_rd_data, exp);
	endtask

	task automatic stop_test();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the sequence needs well under 4000 cycles
	initial begin
		#20000;
		fails++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		#1;
		port_latch = 8'($random(seed));
		resetn = 1'b1;
		// Let the pin mux settle on the new latch value
		#1;
		check({8'h00, osc_control_reg}, 16'h0000);
		check({15'h0, map_write_lock}, 16'h0000);
		check({8'h00, pin_out}, {8'h00, port_latch});
		// Every output code on pins 0 and 1, with random peripheral levels
		for (int i = 0; i < 8; i++) begin
			map_write(5'h09, {3'h0, codes[(i + 1) % 8], 3'h0, codes[i]});
			periph = 7'($random(seed));
			port_latch = 8'($random(seed));
			#1;
			fcode = codes[(i + 1) % 8];
			check({15'h0, pin_out[0]}, {15'h0, exp_pin(codes[i], periph, port_latch[0])});
			check({15'h0, pin_out[1]}, {15'h0, exp_pin(fcode, periph, port_latch[1])});
		end
		// Programmed fuse: many sessions
		osc_config_word = 8'h00;
		#1;
		check({15'h0, single_session_lock_fuse}, 16'h0000);
		map_write(5'h03, 16'h1234);
		read_check(5'h03, 16'h1234);
		lock_seq(1'b1);
		check({8'h00, osc_control_reg}, 16'h0040);
		map_write(5'h03, 16'hbeef);
		map_write(5'h0a, 16'h0303);
		read_check(5'h03, 16'h1234);
		read_check(5'h0a, 16'h0000);
		// Wrong second key, then key broken by a map write
		osc_write(8'h46);
		osc_write(8'h55);
		osc_write(8'h00);
		check({15'h0, map_write_lock}, 16'h0001);
		osc_write(8'h46);
		map_write(5'h01, 16'h0001);
		osc_write(8'h57);
		osc_write(8'h00);
		check({15'h0, map_write_lock}, 16'h0001);
		// Key broken by a high byte write
		osc_write(8'h46);
		osc_write_high(8'h00);
		osc_write(8'h57);
		osc_write(8'h00);
		check({15'h0, map_write_lock}, 16'h0001);
		lock_seq(1'b0);
		check({15'h0, map_write_lock}, 16'h0000);
		// Lock stays open across many writes
		for (int k = 0; k < 17; k++)
			map_write(k[4:0], {8'h00, 3'h0, codes[k % 8]});
		check({15'h0, map_write_lock}, 16'h0000);
		read_check(5'h10, {11'h0, codes[0]});
		read_check(5'h0f, {11'h0, codes[7]});
		// Low fields of maps 9 to 12 route pins 0, 2, 4, 6; high fields stay at the latch
		for (int p = 0; p < 8; p++) begin
			fcode = (p % 2 == 1) ? 5'h00 : codes[(9 + p / 2) % 8];
			check({15'h0, pin_out[p]}, {15'h0, exp_pin(fcode, periph, port_latch[p])});
		end
		map_write(5'h11, 16'hffff);
		read_check(5'h11, 16'h0000);
		// Unprogrammed fuse: one session only
		osc_config_word = 8'h20;
		#1;
		check({15'h0, single_session_lock_fuse}, 16'h0001);
		lock_seq(1'b1);
		lock_seq(1'b0);
		check({15'h0, map_write_lock}, 16'h0001);
		map_write(5'h02, 16'h0abc);
		read_check(5'h02, {11'h0, codes[2]});
		check({15'h0, config_mismatch_reset}, 16'h0000);
		// Device reset reopens the maps
		resetn = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		check({15'h0, map_write_lock}, 16'h0000);
		map_write(5'h02, 16'h0abc);
		read_check(5'h02, 16'h0abc);
		check({15'h0, config_mismatch_reset}, 16'h0000);
		stop_test();
	end
endmodule
